/* File: tmr_core.sv */
`timescale 1ns/1ps
module tmr_core (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register port
   input wire tmr_pkg::tmr_bus_t bus,
   output logic [7:0] rdata,
   // Interrupt acknowledge from the processor
   input wire logic wrap_ack,
   input wire logic match_ack,
   // Event flags
   output logic wrap_flag,
   output logic match_flag,
   // Output pin
   output tmr_pkg::tmr_pin_t pin
);
   import tmr_pkg::*;

   tmr_ctrl_t ctrl;
   tmr_ctrl_t w_ctrl;
   logic [7:0] count_value;
   logic [7:0] compare_buf;
   logic [7:0] compare_live;
   logic compare_output_state;
   logic match_block;
   logic port_data;
   logic pin_direction_bit;

   logic [7:0] next_count;
   logic [7:0] next_compare_live;
   logic [7:0] next_rdata;
   logic next_state;
   logic next_block;
   logic next_wrap;
   logic next_match;
   tmr_pin_t next_pin;

   wire tick;
   wire wr_ctrl;
   wire wr_count;
   wire wr_compare;
   wire wr_flags;
   wire wr_port;
   wire [1:0] waveform_select;
   wire [1:0] action;
   wire is_pwm;
   wire is_ctc;
   wire is_fast;
   wire [7:0] cmp_val;
   wire cmp_eq;
   wire at_max;
   wire match_ev;
   wire top_ev;
   wire ctc_clear;
   wire force_ev;
   wire wrap_set;
   wire wrap_clr;
   wire match_clr;
   wire override;

   // Output state after a non-PWM match or a forced match
   function automatic logic np_action(input logic st, input logic [1:0] act);
      case (act)
         ACT_TOGGLE: np_action = ~st;
         ACT_CLEAR: np_action = 1'b0;
         ACT_SET: np_action = 1'b1;
         default: np_action = st;
      endcase
   endfunction

   // Fast PWM output; bottom wins so compare at maximum stays steady
   function automatic logic pwm_action(input logic st, input logic [1:0] act,
                                       input logic m, input logic bottom);
      case (act)
         ACT_TOGGLE: pwm_action = m ? ~st : st;
         ACT_CLEAR: pwm_action = bottom ? 1'b1 : (m ? 1'b0 : st);
         ACT_SET: pwm_action = bottom ? 1'b0 : (m ? 1'b1 : st);
         default: pwm_action = st;
      endcase
   endfunction

   tmr_prescale u_prescale (
      .mclk(mclk),
      .reset_n(reset_n),
      .clk_sel(ctrl.clk_sel),
      .tick(tick)
   );

   // Address decode
   assign w_ctrl = tmr_ctrl_t'(bus.wdata);
   assign wr_ctrl = bus.wr && (bus.addr == ADDR_CTRL);
   assign wr_count = bus.wr && (bus.addr == ADDR_COUNT);
   assign wr_compare = bus.wr && (bus.addr == ADDR_COMPARE);
   assign wr_flags = bus.wr && (bus.addr == ADDR_FLAGS);
   assign wr_port = bus.wr && (bus.addr == ADDR_PORT);

   // Mode decode
   assign waveform_select = {ctrl.wgm_high, ctrl.wgm_low};
   assign action = ctrl.compare_output_action;
   assign is_ctc = (waveform_select == WGM_CTC);
   assign is_fast = (waveform_select == WGM_FAST);
   assign is_pwm = is_fast || (waveform_select == WGM_PHASE);

   // Compare path; PWM modes see the loaded copy
   assign cmp_val = is_pwm ? compare_live : compare_buf;
   assign cmp_eq = (count_value == cmp_val);
   assign at_max = (count_value == COUNT_MAX);
   assign match_ev = tick && cmp_eq && !match_block;
   assign top_ev = tick && at_max;
   assign ctc_clear = is_ctc && match_ev;

   // Forced match only in non-PWM modes, using the written action
   assign force_ev = wr_ctrl && w_ctrl.force_match_strobe
                     && ({w_ctrl.wgm_high, w_ctrl.wgm_low} != WGM_FAST)
                     && ({w_ctrl.wgm_high, w_ctrl.wgm_low} != WGM_PHASE);

   // Wrap when leaving maximum toward zero, except in phase mode; a count write takes priority
   assign wrap_set = top_ev && !wr_count
                     && (waveform_select != WGM_PHASE);
   assign wrap_clr = wrap_ack || (wr_flags && bus.wdata[FLAG_WRAP_BIT]);
   assign match_clr = match_ack || (wr_flags && bus.wdata[FLAG_MATCH_BIT]);

   // Pin source chosen by action alone
   assign override = (action != ACT_NONE);

   // Counter: software write wins over clear and count
   always_comb begin
      if (wr_count) begin
         next_count = bus.wdata;
      end else if (ctc_clear) begin
         next_count = COUNT_BOTTOM;
      end else if (tick) begin
         next_count = count_value + COUNT_STEP;
      end else begin
         next_count = count_value;
      end
   end

   // Match block lasts until the next tick
   always_comb begin
      if (wr_count) begin
         next_block = 1'b1;
      end else if (tick) begin
         next_block = 1'b0;
      end else begin
         next_block = match_block;
      end
   end

   // Buffered compare load at top in PWM modes
   always_comb begin
      if (!is_pwm || top_ev) begin
         next_compare_live = compare_buf;
      end else begin
         next_compare_live = compare_live;
      end
   end

   // Flags: a set in the clearing cycle wins
   always_comb begin
      next_wrap = wrap_set || (wrap_flag && !wrap_clr);
      next_match = match_ev || (match_flag && !match_clr);
   end

   // Output state
   always_comb begin
      if (force_ev) begin
         next_state = np_action(compare_output_state,
                                w_ctrl.compare_output_action);
      end else if (is_fast) begin
         next_state = pwm_action(compare_output_state, action,
                                 match_ev, top_ev);
      end else if (match_ev && (waveform_select != WGM_PHASE)) begin
         next_state = np_action(compare_output_state, action);
      end else begin
         next_state = compare_output_state;
      end
   end

   // Pin drive
   always_comb begin
      next_pin.out = override ? compare_output_state : port_data;
      next_pin.oe = pin_direction_bit;
   end

   // Read mux
   always_comb begin
      next_rdata = READ_ZERO;
      if (bus.rd) begin
         case (bus.addr)
            ADDR_CTRL: next_rdata = {1'b0, bus.rd ? ctrl[6:0] : 7'h00};
            ADDR_COUNT: next_rdata = count_value;
            ADDR_COMPARE: next_rdata = compare_buf;
            ADDR_FLAGS: next_rdata = {6'h00, match_flag, wrap_flag};
            ADDR_PORT: next_rdata = {5'h00, compare_output_state,
                                     pin_direction_bit, port_data};
            default: next_rdata = READ_ZERO;
         endcase
      end
   end

   // Control register; strobe bit is never stored
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= tmr_ctrl_t'(REG_RESET);
      end else if (wr_ctrl) begin
         ctrl <= {1'b0, bus.wdata[6:0]};
      end
   end

   // Port data and direction
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         port_data <= 1'b0;
         pin_direction_bit <= 1'b0;
      end else if (wr_port) begin
         port_data <= bus.wdata[PORT_DATA_BIT];
         pin_direction_bit <= bus.wdata[PORT_DIR_BIT];
      end
   end

   // Compare buffer written by software
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         compare_buf <= REG_RESET;
      end else if (wr_compare) begin
         compare_buf <= bus.wdata;
      end
   end

   // Counter and compare datapath
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count_value <= REG_RESET;
         compare_live <= REG_RESET;
         match_block <= 1'b0;
      end else begin
         count_value <= next_count;
         compare_live <= next_compare_live;
         match_block <= next_block;
      end
   end

   // Flags and output state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wrap_flag <= 1'b0;
         match_flag <= 1'b0;
         compare_output_state <= 1'b0;
      end else begin
         wrap_flag <= next_wrap;
         match_flag <= next_match;
         compare_output_state <= next_state;
      end
   end

   // Registered outputs; one mclk behind the state that feeds them
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pin <= tmr_pin_t'(2'h0);
         rdata <= READ_ZERO;
      end else begin
         pin <= next_pin;
         rdata <= next_rdata;
      end
   end

endmodule

/* File: tmr_pkg.sv */
package tmr_pkg;

   // Register port addresses
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_COUNT = 3'h1;
   localparam logic [2:0] ADDR_COMPARE = 3'h2;
   localparam logic [2:0] ADDR_FLAGS = 3'h3;
   localparam logic [2:0] ADDR_PORT = 3'h4;

   // Count landmarks
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_STEP = 8'h01;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Waveform select values
   localparam logic [1:0] WGM_NORMAL = 2'h0;
   localparam logic [1:0] WGM_PHASE = 2'h1;
   localparam logic [1:0] WGM_CTC = 2'h2;
   localparam logic [1:0] WGM_FAST = 2'h3;

   // Compare output actions
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   // Flag and port register bit positions
   localparam int FLAG_WRAP_BIT = 0;
   localparam int FLAG_MATCH_BIT = 1;
   localparam int PORT_DATA_BIT = 0;
   localparam int PORT_DIR_BIT = 1;

   // Clock select codes and prescale masks
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV32 = 3'h3;
   localparam logic [2:0] CS_DIV64 = 3'h4;
   localparam logic [2:0] CS_DIV128 = 3'h5;
   localparam logic [2:0] CS_DIV256 = 3'h6;
   localparam logic [9:0] MASK_DIV1 = 10'h000;
   localparam logic [9:0] MASK_DIV8 = 10'h007;
   localparam logic [9:0] MASK_DIV32 = 10'h01f;
   localparam logic [9:0] MASK_DIV64 = 10'h03f;
   localparam logic [9:0] MASK_DIV128 = 10'h07f;
   localparam logic [9:0] MASK_DIV256 = 10'h0ff;
   localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
   localparam logic [9:0] DIV_STEP = 10'h001;
   localparam logic [9:0] DIV_RESET = 10'h000;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic force_match_strobe;
      logic wgm_low;
      logic [1:0] compare_output_action;
      logic wgm_high;
      logic [2:0] clk_sel;
   } tmr_ctrl_t;

   // Register port request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tmr_bus_t;

   // Pin drive
   typedef struct packed {
      logic out;
      logic oe;
   } tmr_pin_t;

endpackage

/* File: tmr_prescale.sv */
`timescale 1ns/1ps
module tmr_prescale (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Clock select
   input wire logic [2:0] clk_sel,
   // Timer tick, one mclk wide
   output logic tick
);
   import tmr_pkg::*;

   logic [9:0] div;
   logic [9:0] mask;

   function automatic logic [9:0] sel_mask(input logic [2:0] sel);
      case (sel)
         CS_DIV1: sel_mask = MASK_DIV1;
         CS_DIV8: sel_mask = MASK_DIV8;
         CS_DIV32: sel_mask = MASK_DIV32;
         CS_DIV64: sel_mask = MASK_DIV64;
         CS_DIV128: sel_mask = MASK_DIV128;
         CS_DIV256: sel_mask = MASK_DIV256;
         default: sel_mask = MASK_DIV1024;
      endcase
   endfunction

   // Free running divider; phase is not reset on select change
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         div <= DIV_RESET;
      end else begin
         div <= div + DIV_STEP;
      end
   end

   assign mask = sel_mask(clk_sel);
   assign tick = (clk_sel != CS_STOP) && ((div & mask) == mask);

endmodule

/* File: tmr_load.sv */
`timescale 1ns/1ps
module tmr_load (
   // Pin from the timer
   input wire tmr_pkg::tmr_pin_t pin,
   // Level on the board
   output logic level
);
   import tmr_pkg::*;
   // Pull-up holds the line while the pin is an input
   assign level = pin.oe ? pin.out : 1'b1;
endmodule

/* File: tmr_checker.sv */
`timescale 1ns/1ps
module tmr_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register port
   input wire tmr_pkg::tmr_bus_t bus,
   input wire logic [7:0] rdata,
   // Flags
   input wire logic wrap_ack,
   input wire logic match_ack,
   input wire logic wrap_flag,
   input wire logic match_flag,
   // Pin
   input wire tmr_pkg::tmr_pin_t pin
);
   import tmr_pkg::*;
   logic [7:0] ctrl;
   logic [1:0] port;
   wire wr_ctrl = bus.wr && bus.addr == ADDR_CTRL;
   wire wr_flag = bus.wr && bus.addr == ADDR_FLAGS;
   wire clr_wrap = wrap_ack || (wr_flag && bus.wdata[FLAG_WRAP_BIT]);
   wire clr_match = match_ack || (wr_flag && bus.wdata[FLAG_MATCH_BIT]);
   wire stopped = ctrl[2:0] == CS_STOP;
   wire [1:0] act = ctrl[5:4];
   wire pdata = port[0];
   wire pdir = port[1];
   // Shadows of bus writes keep the checker on the ports alone
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= 8'h00;
         port <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= {1'b0, bus.wdata[6:0]};
         end
         if (bus.wr && bus.addr == ADDR_PORT) begin
            port <= bus.wdata[1:0];
         end
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence s_rd(logic [2:0] a);
      bus.rd && bus.addr == a;
   endsequence
   AST_PIN_SOURCE: assert property ($past(act) == ACT_NONE |-> pin.out == $past(pdata))
      else $error("pin ignores port data");
   AST_PIN_STATE: assert property (s_rd(ADDR_PORT) ##0 act != ACT_NONE |=> pin.out == rdata[2])
      else $error("pin ignores output state");
   AST_PIN_DIR: assert property (pin.oe == $past(pdir))
      else $error("pin enable ignores direction");
   AST_WRAP_HOLD: assert property ($fell(wrap_flag) |-> $past(clr_wrap))
      else $error("wrap flag cleared by itself");
   AST_MATCH_HOLD: assert property ($fell(match_flag) |-> $past(clr_match))
      else $error("match flag cleared by itself");
   AST_FORCE_QUIET: assert property (wr_ctrl && bus.wdata[7] && stopped |=> !$rose(match_flag))
      else $error("force set match flag");
   AST_STOP_QUIET: assert property (stopped [*3] |-> !$rose(wrap_flag) && !$rose(match_flag))
      else $error("flag set while stopped");
   AST_FLAG_READ: assert property (s_rd(ADDR_FLAGS) |=> rdata[1:0] == {$past(match_flag), $past(wrap_flag)})
      else $error("flag read wrong");
   AST_CTRL_READ: assert property (s_rd(ADDR_CTRL) |=> rdata == $past(ctrl))
      else $error("control read wrong");
   AST_UNMAPPED: assert property (bus.rd && bus.addr > ADDR_PORT |=> rdata == READ_ZERO)
      else $error("unmapped read not zero");
endmodule
bind tmr_core tmr_checker chk (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
   .wrap_ack(wrap_ack), .match_ack(match_ack), .wrap_flag(wrap_flag),
   .match_flag(match_flag), .pin(pin));

/* File: tmr_core_tb.sv */
`timescale 1ns/1ps
module tmr_core_tb;
   import tmr_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   tmr_bus_t bus = '0;
   logic wrap_ack = 1'b0;
   logic match_ack = 1'b0;
   logic [7:0] rdata;
   logic wrap_flag;
   logic match_flag;
   tmr_pin_t pin;
   logic level;
   int failures = 0;
   int comparisons = 0;
   int n;
   int h;
   int e;
   int k;
   logic [1:0] fa [5] = '{ACT_SET, ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_TOGGLE};
   logic fs [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
   int sh [6] = '{0, 3, 5, 6, 7, 8};
   logic [7:0] wc [3] = '{8'hf0, 8'h10, 8'h20};
   logic [7:0] wp [3] = '{8'h00, 8'h05, 8'h20};
   logic [7:0] wm [3] = '{8'h01, 8'h09, 8'h09};
   logic [7:0] pc [5] = '{8'h40, 8'h40, 8'hff, 8'hff, 8'h00};
   logic [1:0] pa [5] = '{ACT_CLEAR, ACT_SET, ACT_CLEAR, ACT_SET, ACT_CLEAR};
   int ph [5] = '{65, 191, 256, 0, 1};
   always #12.5 mclk = ~mclk;
   tmr_core dut (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
      .wrap_ack(wrap_ack), .match_ack(match_ack), .wrap_flag(wrap_flag),
      .match_flag(match_flag), .pin(pin));
   tmr_load load (.pin(pin), .level(level));
   task automatic final_report();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Pin level settles one mclk after its source; look past the edge
   task automatic see(input logic x);
      #1;
      chk({15'h0, level}, {15'h0, x});
      @(posedge mclk);
   endtask
   // An idle cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus <= '0;
      @(posedge mclk);
   endtask
   task automatic rdp(input logic [2:0] a, input logic [7:0] x);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus <= '0;
      #1;
      chk({8'h00, rdata}, {8'h00, x});
      @(posedge mclk);
   endtask
   task automatic edges(input int c);
      logic last;
      #1;
      last = level;
      n = 0;
      h = 0;
      repeat (c) begin
         @(posedge mclk);
         #1;
         n += (level !== last);
         h += (level === 1'b1);
         last = level;
      end
      @(posedge mclk);
   endtask
   task automatic wait_wrap(input int lim);
      int i;
      i = 0;
      while (wrap_flag !== 1'b1 && i < lim) begin
         @(posedge mclk);
         i++;
      end
      if (i >= lim) begin
         failures++;
         final_report();
      end
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      for (k = 0; k < 6; k++) rdp(k[2:0], 8'h00);
      see(1'b1);
      $display("test reset done");
      wr(ADDR_COUNT, 8'h33);
      for (k = 0; k < 5; k++) begin
         wr(ADDR_CTRL, {1'b1, 1'b0, fa[k], 1'b0, CS_STOP});
         rdp(ADDR_PORT, {5'h00, fs[k], 2'b00});
      end
      rdp(ADDR_COUNT, 8'h33);
      rdp(ADDR_FLAGS, 8'h00);
      rdp(ADDR_CTRL, 8'h10);
      wr(ADDR_PORT, 8'h02);
      see(1'b1);
      wr(ADDR_CTRL, 8'h00);
      see(1'b0);
      wr(ADDR_PORT, 8'h00);
      see(1'b1);
      $display("test force done");
      // Count at maximum: first tick wraps to zero, then matches every tick
      wr(ADDR_COUNT, 8'hff);
      wr(ADDR_COMPARE, 8'h00);
      wr(ADDR_PORT, 8'h02);
      for (k = 0; k < 6; k++) begin
         wr(ADDR_CTRL, {1'b0, 1'b0, ACT_TOGGLE, 1'b1, 3'(k + 1)});
         repeat (4) @(posedge mclk);
         edges(256);
         e = 256 >> sh[k];
         chk(n[15:0], e[15:0]);
      end
      wr(ADDR_CTRL, 8'h00);
      rdp(ADDR_FLAGS, 8'h03);
      match_ack <= 1'b1;
      wrap_ack <= 1'b1;
      @(posedge mclk);
      match_ack <= 1'b0;
      wrap_ack <= 1'b0;
      @(posedge mclk);
      rdp(ADDR_FLAGS, 8'h00);
      $display("test clear on match done");
      for (k = 0; k < 3; k++) begin
         wr(ADDR_COUNT, wc[k]);
         wr(ADDR_COMPARE, wp[k]);
         wr(ADDR_CTRL, wm[k]);
         wait_wrap(300);
         wr(ADDR_CTRL, 8'h00);
         wr(ADDR_FLAGS, 8'h03);
         rdp(ADDR_FLAGS, 8'h00);
      end
      $display("test wrap done");
      for (k = 0; k < 5; k++) begin
         wr(ADDR_COMPARE, pc[k]);
         wr(ADDR_CTRL, {1'b0, 1'b1, pa[k], 1'b1, CS_DIV1});
         repeat (300) @(posedge mclk);
         edges(256);
         chk(h[15:0], ph[k][15:0]);
      end
      chk({15'h0, wrap_flag}, 16'h1);
      $display("test fast pwm done");
      final_report();
   end
endmodule
